// *** sdid_pkg.sv ***
package sdid_pkg;
    // bus geometry
    localparam int          AXI_ADDR_W     = 32;
    localparam int          AXI_DATA_W     = 32;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // register byte offsets
    localparam logic [31:0] CTRL_OFFSET    = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0004;
    localparam logic [31:0] POS_OFFSET     = 32'h0000_0008;

    // register index, decoded from the whole word address (bits 31:2)
    typedef enum logic [1:0] {
        SDID_REG_CTRL   = 2'h0,
        SDID_REG_STATUS = 2'h1,
        SDID_REG_POS    = 2'h2,
        SDID_REG_NONE   = 2'h3
    } sdid_reg_t;

    // control field positions
    localparam int          CTRL_W         = 5;
    localparam int          CTRL_TWO_STROBE = 0; // 0 step/direction, 1 two-strobe
    localparam int          CTRL_STEP_INV  = 1; // falling edge / active-low forward strobe
    localparam int          CTRL_REV_INV   = 2; // inverts rotation-sense / reverse request
    localparam int          CTRL_SOURCING  = 3; // sourcing or differential input wiring
    localparam int          CTRL_EN_WIRED  = 4; // enable line is connected
    localparam logic [4:0]  CTRL_RESET     = 5'h00;

    // status field positions
    localparam int          ST_DRIVE_ON    = 0;
    localparam int          ST_DIR         = 1;
    localparam int          ST_STEP_LVL    = 2;
    localparam int          ST_REV_LVL     = 3;
    localparam int          ST_EN_LVL      = 4;

    // input index in the synchroniser
    localparam int          IN_STEP        = 0;
    localparam int          IN_REV         = 1;
    localparam int          IN_EN          = 2;
    localparam int          IN_W           = 3;

    // timing the controller must honour, checked nowhere in hardware
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam int          STROBE_MIN_PS  = 2500000;
    localparam int          DIR_SETUP_PS   = 5000000;
    localparam int          EN_SETUP_PS    = 5000000;
    localparam int          STROBE_MIN_CYC = (STROBE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          DIR_SETUP_CYC  = (DIR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          EN_SETUP_CYC   = (EN_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// *** sdid_sync.sv ***
module sdid_sync
    import sdid_pkg::*;
#(
    parameter int W = IN_W
)(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // two flops per isolated input; only the second stage is ever looked at
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    meta_r[gi] <= 1'b0;
                    q[gi]      <= 1'b0;
                end
                else
                begin
                    meta_r[gi] <= d[gi];
                    q[gi]      <= meta_r[gi];
                end
            end
        end
    endgenerate
endmodule

// *** sdid_top.sv ***
// Function
// - step/direction mode counts one step per selected step strobe edge.
// - two-strobe mode uses step strobe as forward request, level polarity selectable.
// - step/direction mode takes rotation-sense level as direction for following steps.
// - two-strobe mode uses rotation-sense as reverse request, polarity selectable.
// - drive runs at enabling level; high for sinking, inverted for sourcing.
// - unconnected enable line means drive enabled.
// - reset gives step/direction mode, rising edge for sinking, opposite for sourcing.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
module sdid_top
    import sdid_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  step_strobe_in,
    input  wire logic                  rotation_sense_in,
    input  wire logic                  drive_enable_in,
    output logic                       step_pulse_r,
    output logic                       step_dir_r,
    output logic                       drive_on_r
);
    // address decode shared by the read and write paths
    function automatic sdid_reg_t reg_decode(input logic [AXI_ADDR_W-1:0] a);
        logic [AXI_ADDR_W-1:0] base;
        base = {a[AXI_ADDR_W-1:2], 2'h0};
        if (base == CTRL_OFFSET)
            reg_decode = SDID_REG_CTRL;
        else if (base == STATUS_OFFSET)
            reg_decode = SDID_REG_STATUS;
        else if (base == POS_OFFSET)
            reg_decode = SDID_REG_POS;
        else
            reg_decode = SDID_REG_NONE;
    endfunction

    logic [CTRL_W-1:0]     ctrl_r;
    logic [IN_W-1:0]       in_s;
    logic                  fwd_prev_r;
    logic                  rev_prev_r;
    logic                  fwd_act;
    logic                  rev_act;
    logic                  fwd_rise;
    logic                  rev_rise;
    logic                  step_ev;
    logic                  dir_nxt;
    logic                  drive_on_nxt;
    logic [31:0]           pos_r;
    logic [AXI_ADDR_W-1:0] awaddr_r;
    logic [AXI_DATA_W-1:0] wdata_r;
    logic [3:0]            wstrb_r;
    logic                  aw_held_r;
    logic                  w_held_r;
    logic                  wr_go;
    sdid_reg_t             wr_idx;
    logic [AXI_DATA_W-1:0] rd_mux;
    logic [1:0]            rd_resp;

    sdid_sync #(.W(IN_W)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({drive_enable_in, rotation_sense_in, step_strobe_in}),
        .q       (in_s)
    );

    // sourcing wiring flips every sense, so the reset default edge flips with it
    always_comb
    begin
        fwd_act  = in_s[IN_STEP] ^ ctrl_r[CTRL_STEP_INV] ^ ctrl_r[CTRL_SOURCING];
        rev_act  = in_s[IN_REV] ^ ctrl_r[CTRL_REV_INV] ^ ctrl_r[CTRL_SOURCING];
        fwd_rise = fwd_act & ~fwd_prev_r;
        rev_rise = rev_act & ~rev_prev_r;
        // an unwired enable reads as enabled
        if (ctrl_r[CTRL_EN_WIRED])
            drive_on_nxt = in_s[IN_EN] ^ ctrl_r[CTRL_SOURCING];
        else
            drive_on_nxt = 1'b1;
    end

    // step decode; simultaneous forward and reverse requests cancel out
    always_comb
    begin
        step_ev = 1'b0;
        dir_nxt = step_dir_r;
        if (drive_on_r)
        begin
            if (!ctrl_r[CTRL_TWO_STROBE])
            begin
                dir_nxt = rev_act;
                step_ev = fwd_rise;
            end
            else if (fwd_rise ^ rev_rise)
            begin
                step_ev = 1'b1;
                dir_nxt = rev_rise;
            end
        end
    end

    // edge history is kept even while disabled so enabling never fakes an edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fwd_prev_r <= 1'b0;
            rev_prev_r <= 1'b0;
        end
        else
        begin
            fwd_prev_r <= fwd_act;
            rev_prev_r <= rev_act;
        end
    end

    // step outputs and position; 1 on the direction output means reverse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            step_pulse_r <= 1'b0;
            step_dir_r   <= 1'b0;
            pos_r        <= 32'h0000_0000;
            drive_on_r   <= 1'b1;
        end
        else
        begin
            step_pulse_r <= step_ev;
            step_dir_r   <= dir_nxt;
            drive_on_r   <= drive_on_nxt;
            if (step_ev)
                pos_r <= dir_nxt ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001;
        end
    end

    // write channel: address and data taken in either order, answered once both are held
    assign wr_go  = aw_held_r & w_held_r & ~bvalid;
    assign wr_idx = reg_decode(awaddr_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 32'h0000_0000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awaddr_r  <= awaddr;
                aw_held_r <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
                w_held_r <= 1'b1;
                wready   <= 1'b0;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (wr_idx == SDID_REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // only the low byte of control is writable; status and position are read-only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_r <= CTRL_RESET;
        else if (wr_go && wr_idx == SDID_REG_CTRL && wstrb_r[0])
            ctrl_r <= wdata_r[CTRL_W-1:0];
    end

    // read data mux; unmapped reads return zero with an error
    always_comb
    begin
        rd_mux  = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        case (reg_decode(araddr))
            SDID_REG_CTRL:   rd_mux[CTRL_W-1:0] = ctrl_r;
            SDID_REG_STATUS:
            begin
                rd_mux[ST_DRIVE_ON] = drive_on_r;
                rd_mux[ST_DIR]      = step_dir_r;
                rd_mux[ST_STEP_LVL] = in_s[IN_STEP];
                rd_mux[ST_REV_LVL]  = in_s[IN_REV];
                rd_mux[ST_EN_LVL]   = in_s[IN_EN];
            end
            SDID_REG_POS:    rd_mux = pos_r;
            default:         rd_resp = RESP_SLVERR;
        endcase
    end

    // read channel: one read outstanding, data captured at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_mux;
                rresp   <= rd_resp;
            end
            if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // checks on the step decode, the enable and the reset defaults
    sequence s_sd_ready;
        !ctrl_r[CTRL_TWO_STROBE] && drive_on_r;
    endsequence
    sequence s_raw_rise;
        !step_strobe_in ##1 step_strobe_in [*3];
    endsequence

    a_sd_edge_step: assert property (@(posedge aclk) disable iff (!aresetn)
        s_sd_ready ##0 fwd_rise |=> step_pulse_r && (pos_r != $past(pos_r)))
        else $error("step edge did not produce a step");
    a_fwd_strobe_step: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r[CTRL_TWO_STROBE] && drive_on_r && fwd_rise && !rev_rise
        |=> step_pulse_r && !step_dir_r && pos_r == $past(pos_r) + 32'h0000_0001)
        else $error("forward request did not step forward");
    a_sd_dir_level: assert property (@(posedge aclk) disable iff (!aresetn)
        s_sd_ready ##0 (fwd_rise && rev_act)
        |=> step_dir_r && pos_r == $past(pos_r) - 32'h0000_0001)
        else $error("direction level not applied to step");
    a_rev_strobe_step: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r[CTRL_TWO_STROBE] && drive_on_r && rev_rise && !fwd_rise
        |=> step_pulse_r && step_dir_r && pos_r == $past(pos_r) - 32'h0000_0001)
        else $error("reverse request did not step reverse");
    a_enable_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_r[CTRL_EN_WIRED] && !ctrl_r[CTRL_SOURCING]) [*3] ##0 (drive_enable_in [*3])
        |=> ##1 drive_on_r)
        else $error("sinking enable high did not run the drive");
    a_unwired_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_r[CTRL_EN_WIRED] |=> drive_on_r)
        else $error("unwired enable left drive off");
    a_reset_default: assert property (@(posedge aclk)
        $rose(aresetn) |-> ctrl_r == CTRL_RESET && drive_on_r && !step_pulse_r)
        else $error("control not at default after reset");
    a_sync_one_step: assert property (@(posedge aclk) disable iff (!aresetn)
        s_raw_rise ##0 (ctrl_r == CTRL_RESET && drive_on_r) |=> step_pulse_r ##1 !step_pulse_r)
        else $error("strobe edge did not give exactly one step");
    a_disabled_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !drive_on_r |=> !step_pulse_r && $stable(pos_r) && $stable(step_dir_r))
        else $error("disabled drive changed position or direction");
endmodule

// *** sdid_motion_model.sv ***
module sdid_motion_model
    import sdid_pkg::*;
(
    input  wire logic aclk,
    output logic      step_strobe_in,
    output logic      rotation_sense_in,
    output logic      drive_enable_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins start low, like an idle open-collector controller
    initial
    begin
        step_strobe_in    = 1'b0;
        rotation_sense_in = 1'b0;
        drive_enable_in   = 1'b0;
    end

    task automatic idle_for(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // one strobe on the step line or the reverse line; widths jitter above the minimum
    task automatic strobe(input logic on_rev, input logic act);
        @(posedge aclk);
        if (on_rev)
            rotation_sense_in <= act;
        else
            step_strobe_in <= act;
        idle_for(STROBE_MIN_CYC + 2 + $urandom_range(7));
        if (on_rev)
            rotation_sense_in <= !act;
        else
            step_strobe_in <= !act;
        idle_for(STROBE_MIN_CYC + 2 + $urandom_range(7));
    endtask

    // direction settles well ahead of the next strobe edge
    task automatic set_dir(input logic lvl);
        @(posedge aclk);
        rotation_sense_in <= lvl;
        idle_for(DIR_SETUP_CYC + 4);
    endtask

    // enable settles before any later direction change
    task automatic set_en(input logic lvl);
        @(posedge aclk);
        drive_enable_in <= lvl;
        idle_for(EN_SETUP_CYC + 4);
    endtask

    // idle levels for a new wiring; one spurious edge is tolerated here
    task automatic set_idle(input logic stp, input logic rev);
        @(posedge aclk);
        step_strobe_in    <= stp;
        rotation_sense_in <= rev;
        idle_for(DIR_SETUP_CYC + 4);
    endtask
endmodule

// *** step_dir_input_decoder_bench.sv ***
module step_dir_input_decoder_bench
    import sdid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        step_strobe_in, rotation_sense_in, drive_enable_in;
    logic        step_pulse_r, step_dir_r, drive_on_r;
    int          bad_count = 0;
    int          checks_done = 0;
    int          pulse_count = 0;
    logic [4:0]  cfg [7] = '{5'h00, 5'h02, 5'h08, 5'h04, 5'h01, 5'h03, 5'h0d};

    sdid_top sdid_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .step_strobe_in(step_strobe_in), .rotation_sense_in(rotation_sense_in),
        .drive_enable_in(drive_enable_in), .step_pulse_r(step_pulse_r),
        .step_dir_r(step_dir_r), .drive_on_r(drive_on_r));

    sdid_motion_model ctrl_model (.aclk(aclk), .step_strobe_in(step_strobe_in),
        .rotation_sense_in(rotation_sense_in), .drive_enable_in(drive_enable_in));

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // step events seen at the output, one per high cycle
    always @(posedge aclk)
        if (step_pulse_r === 1'b1)
            pulse_count <= pulse_count + 1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // active pin level of a strobe: inversion and sourcing wiring each flip it
    function automatic logic act_level(input logic inv, input logic src);
        return !(inv ^ src);
    endfunction

    // ready is read before the edge's flop updates land; local flags track each channel,
    // since valid itself only changes after the edge and would keep the loop going one cycle too long
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (aw_open || w_open)
        begin
            @(posedge aclk);
            if (aw_open && awready === 1'b1)
            begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && wready === 1'b1)
            begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    initial
    begin
        logic [31:0] d, base;
        logic [1:0]  r;
        logic [4:0]  c;
        logic        sact, ract, enl;
        int          n1, p0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr, wstrb} = '0;
        void'($urandom(32'h0f1b2319));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("drive_on after reset", drive_on_r, 1);
        axi_rd(CTRL_OFFSET, d, r);
        check("ctrl reset", d, 0);
        axi_rd(STATUS_OFFSET, d, r);
        check("status low bits", d & 32'h3, 32'h1);
        axi_rd(32'h0000_000c, d, r);
        check("unmapped resp", r, RESP_SLVERR);
        check("unmapped data", d, 0);
        axi_wr(POS_OFFSET, 32'h0000_00ff, 4'hf, r);
        check("pos write resp", r, RESP_SLVERR);
        // a write that leaves byte 0 disabled must not touch the control bits
        axi_wr(CTRL_OFFSET, 32'h0000_001f, 4'he, r);
        check("masked ctrl resp", r, RESP_OKAY);
        axi_rd(CTRL_OFFSET, d, r);
        check("masked ctrl", d, 0);
        $display("test registers done");
        for (int i = 0; i < 7; i++)
        begin
            c    = cfg[i];
            sact = act_level(c[CTRL_STEP_INV], c[CTRL_SOURCING]);
            ract = act_level(c[CTRL_REV_INV], c[CTRL_SOURCING]);
            enl  = act_level(1'b0, c[CTRL_SOURCING]);
            n1   = 1 + $urandom_range(1);
            axi_wr(CTRL_OFFSET, {27'h0, c}, 4'hf, r);
            check("ctrl write resp", r, RESP_OKAY);
            // enable pin held at its disabling level while unwired
            ctrl_model.set_en(!enl);
            ctrl_model.set_idle(!sact, !ract);
            check("drive_on unwired", drive_on_r, 1);
            // status shows the synchronised raw pin levels, before any inversion
            axi_rd(STATUS_OFFSET, d, r);
            check("status levels", d & 32'h1d, {27'h0, !enl, !ract, !sact, 2'b01});
            axi_rd(POS_OFFSET, base, r);
            p0 = pulse_count;
            repeat (n1) ctrl_model.strobe(1'b0, sact);
            check("dir forward", step_dir_r, 0);
            if (!c[CTRL_TWO_STROBE])
                ctrl_model.set_dir(ract);
            ctrl_model.strobe(c[CTRL_TWO_STROBE], c[CTRL_TWO_STROBE] ? ract : sact);
            check("dir reverse", step_dir_r, 1);
            axi_rd(POS_OFFSET, d, r);
            check("position", d, base + 32'(n1) - 32'h1);
            check("pulse count", 32'(pulse_count - p0), 32'(n1 + 1));
            // wire the enable line, hold it disabling, then try to move
            axi_wr(CTRL_OFFSET, {27'h0, c | 5'h10}, 4'hf, r);
            repeat (8) @(posedge aclk);
            check("drive_on disabled", drive_on_r, 0);
            p0 = pulse_count;
            ctrl_model.set_dir(!ract);
            ctrl_model.strobe(1'b0, sact);
            axi_rd(POS_OFFSET, base, r);
            check("position frozen", base, d);
            check("no pulse disabled", 32'(pulse_count - p0), 0);
            check("dir frozen", step_dir_r, 1);
            ctrl_model.set_en(enl);
            check("drive_on enabled", drive_on_r, 1);
            check("dir after enable", step_dir_r, c[CTRL_TWO_STROBE]);
            $display("test config %h done", c);
        end
        // reset in mid-run with the pins at the default idle level, so no real edge follows
        ctrl_model.set_idle(1'b0, 1'b0);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(CTRL_OFFSET, d, r);
        check("ctrl after reset", d, 0);
        axi_rd(POS_OFFSET, d, r);
        check("pos after reset", d, 0);
        check("dir after reset", step_dir_r, 0);
        check("drive_on after mid reset", drive_on_r, 1);
        $display("test mid-run reset done");
        report_and_stop();
    end

    // run is some 72k cycles; cut it off past that but inside the cycle budget
    initial
    begin
        repeat (95000) @(posedge aclk);
        bad_count++;
        report_and_stop();
    end
endmodule
